// File: src/bir_pkg.sv
package bir_pkg;

    // Request numbering
    localparam int unsigned NUM_LEGACY_IRQ = 16;
    localparam int unsigned NUM_TOTAL_IRQ  = 24;
    localparam int unsigned NUM_ROUTED     = 8;
    localparam int unsigned ADV_IRQ_BASE   = 16;

    // Fixed legacy request numbers
    localparam logic [3:0] IRQ_TIMER   = 4'h0;
    localparam logic [3:0] IRQ_KBD     = 4'h1;
    localparam logic [3:0] IRQ_CASCADE = 4'h2;
    localparam logic [3:0] IRQ_FLOPPY  = 4'h6;
    localparam logic [3:0] IRQ_RTC     = 4'h8;
    localparam logic [3:0] IRQ_MOUSE   = 4'hc;
    localparam logic [3:0] IRQ_FPU     = 4'hd;
    localparam logic [3:0] IRQ_ATA_PRI = 4'he;
    localparam logic [3:0] IRQ_ATA_SEC = 4'hf;

    // Reprogrammable defaults for the first serial and parallel port
    localparam logic [3:0] IRQ_COM_DEF = 4'h4;
    localparam logic [3:0] IRQ_LPT_DEF = 4'h7;

    // Legacy numbers a routed input may be steered to: 3-7, 9-12, 14, 15
    localparam logic [15:0] STEER_MASK = 16'hdef8;

    // PCI interrupt pin positions within a connector bundle
    localparam int unsigned PCI_INTA = 0;
    localparam int unsigned PCI_INTB = 1;
    localparam int unsigned PCI_INTC = 2;
    localparam int unsigned PCI_INTD = 3;

    // Values after reset
    localparam logic [23:0] IRQ_RST    = 24'h000000;
    localparam logic [7:0]  ROUTED_RST = 8'h00;
    localparam logic        NMI_RST    = 1'b0;
    localparam logic        ERR_RST    = 1'b0;

    // Controller mode
    typedef enum logic {
        BIR_MODE_LEGACY   = 1'b0,
        BIR_MODE_ADVANCED = 1'b1
    } bir_mode_e;

    // One-hot of a legacy request number
    function automatic logic [15:0] bir_decode(input logic [3:0] sel);
        bir_decode = 16'h0001 << sel;
    endfunction

    // True when a legacy number is legal for steering or reassignment
    function automatic logic bir_steerable(input logic [3:0] sel);
        bir_steerable = |(STEER_MASK & bir_decode(sel));
    endfunction

endpackage

// File: src/bir_route_if.sv
`timescale 1ns/10ps
// Raw PCI interrupt lines in, routed levels out
interface bir_route_if;
    logic       ieee1394_inta_n;
    logic [3:0] conn1_int_n;
    logic [3:0] conn2_int_n;
    logic [3:0] conn3_int_n;
    logic [7:0] routed_irq_input;

    modport src (
        output ieee1394_inta_n,
        output conn1_int_n,
        output conn2_int_n,
        output conn3_int_n,
        input  routed_irq_input
    );

    modport rtr (
        input  ieee1394_inta_n,
        input  conn1_int_n,
        input  conn2_int_n,
        input  conn3_int_n,
        output routed_irq_input
    );
endinterface

// File: src/bir_pci_router.sv
`timescale 1ns/10ps
// Board wiring of PCI lines onto the eight routed inputs
module bir_pci_router (
    bir_route_if.rtr rt
);

    // Lines are active low; shared inputs are a wired-OR of asserted sources
    always_comb begin
        rt.routed_irq_input[0] = ~rt.conn3_int_n[bir_pkg::PCI_INTD];
        rt.routed_irq_input[1] = ~rt.ieee1394_inta_n
                               | ~rt.conn3_int_n[bir_pkg::PCI_INTC];
        rt.routed_irq_input[2] = ~rt.conn3_int_n[bir_pkg::PCI_INTA];
        rt.routed_irq_input[3] = ~rt.conn3_int_n[bir_pkg::PCI_INTB];
        rt.routed_irq_input[4] = ~rt.conn1_int_n[bir_pkg::PCI_INTD]
                               | ~rt.conn2_int_n[bir_pkg::PCI_INTC];
        rt.routed_irq_input[5] = ~rt.conn1_int_n[bir_pkg::PCI_INTA]
                               | ~rt.conn2_int_n[bir_pkg::PCI_INTB];
        rt.routed_irq_input[6] = ~rt.conn1_int_n[bir_pkg::PCI_INTB]
                               | ~rt.conn2_int_n[bir_pkg::PCI_INTA];
        rt.routed_irq_input[7] = ~rt.conn1_int_n[bir_pkg::PCI_INTC]
                               | ~rt.conn2_int_n[bir_pkg::PCI_INTD];
    end

endmodule

// File: src/bir_board_irq_routing.sv
`timescale 1ns/10ps
module bir_board_irq_routing (
    input  wire logic              i_mclk,
    input  wire logic              i_rstn,
    input  wire bir_pkg::bir_mode_e i_mode,
    input  wire logic              i_ieee1394_inta_n,
    input  wire logic [3:0]        i_conn1_int_n,
    input  wire logic [3:0]        i_conn2_int_n,
    input  wire logic [3:0]        i_conn3_int_n,
    input  wire logic [7:0]        i_steer_en,
    input  wire logic [31:0]       i_steer_sel,
    input  wire logic              i_timer_irq,
    input  wire logic              i_kbd_irq,
    input  wire logic              i_cascade_irq,
    input  wire logic              i_floppy_irq,
    input  wire logic              i_rtc_irq,
    input  wire logic              i_fpu_irq,
    input  wire logic              i_mouse_irq,
    input  wire logic              i_ata_pri_irq,
    input  wire logic              i_ata_sec_irq,
    input  wire logic              i_com_irq,
    input  wire logic [3:0]        i_com_sel,
    input  wire logic              i_lpt_irq,
    input  wire logic [3:0]        i_lpt_sel,
    input  wire logic              i_io_chk,
    output logic [23:0]            o_irq,
    output logic                   o_nmi,
    output logic [7:0]             o_routed_irq_input,
    output logic                   o_steer_err
);

    bir_route_if rt ();

    logic [23:0] irq_reg;
    logic [23:0] irq_next;
    logic [7:0]  routed_reg;
    logic        nmi_reg;
    logic        err_reg;
    logic        err_next;
    logic [3:0]  com_num;
    logic [3:0]  lpt_num;

    // Board pins feed the wiring model
    assign rt.ieee1394_inta_n = i_ieee1394_inta_n;
    assign rt.conn1_int_n     = i_conn1_int_n;
    assign rt.conn2_int_n     = i_conn2_int_n;
    assign rt.conn3_int_n     = i_conn3_int_n;

    bir_pci_router u_router (
        .rt (rt)
    );

    // Illegal reassignment falls back to the default, never to a reserved line
    assign com_num = bir_pkg::bir_steerable(i_com_sel) ? i_com_sel : bir_pkg::IRQ_COM_DEF;
    assign lpt_num = bir_pkg::bir_steerable(i_lpt_sel) ? i_lpt_sel : bir_pkg::IRQ_LPT_DEF;

    // Request vector: fixed lines, movable ports, then mode dependent PCI part
    always_comb begin
        irq_next = bir_pkg::IRQ_RST;
        err_next = 1'b0;
        irq_next[bir_pkg::IRQ_TIMER]   = i_timer_irq;
        irq_next[bir_pkg::IRQ_KBD]     = i_kbd_irq;
        irq_next[bir_pkg::IRQ_CASCADE] = i_cascade_irq;
        irq_next[bir_pkg::IRQ_RTC]     = i_rtc_irq;
        irq_next[bir_pkg::IRQ_FPU]     = i_fpu_irq;
        irq_next[15:0] = irq_next[15:0]
                       | ({16{i_floppy_irq}}  & bir_pkg::bir_decode(bir_pkg::IRQ_FLOPPY))
                       | ({16{i_mouse_irq}}   & bir_pkg::bir_decode(bir_pkg::IRQ_MOUSE))
                       | ({16{i_ata_pri_irq}} & bir_pkg::bir_decode(bir_pkg::IRQ_ATA_PRI))
                       | ({16{i_ata_sec_irq}} & bir_pkg::bir_decode(bir_pkg::IRQ_ATA_SEC))
                       | ({16{i_com_irq}}     & bir_pkg::bir_decode(com_num))
                       | ({16{i_lpt_irq}}     & bir_pkg::bir_decode(lpt_num));
        if (i_mode == bir_pkg::BIR_MODE_ADVANCED) begin
            irq_next[23:16] = rt.routed_irq_input;
        end else begin
            for (int k = 0; k < 8; k++) begin
                if (i_steer_en[k]) begin
                    if (bir_pkg::bir_steerable(i_steer_sel[4*k +: 4])) begin
                        // OR-merge lets several inputs share one line
                        irq_next[15:0] = irq_next[15:0]
                            | ({16{rt.routed_irq_input[k]}}
                               & bir_pkg::bir_decode(i_steer_sel[4*k +: 4]));
                    end else begin
                        err_next = 1'b1;
                    end
                end
            end
            irq_next[23:16] = 8'h00;
        end
    end

    // Request outputs, one cycle behind the sources
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            irq_reg <= bir_pkg::IRQ_RST;
        end else begin
            irq_reg <= irq_next;
        end
    end

    // Routed levels held while any source on them stays asserted
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            routed_reg <= bir_pkg::ROUTED_RST;
        end else begin
            routed_reg <= rt.routed_irq_input;
        end
    end

    // Channel check goes straight to the non-maskable line
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            nmi_reg <= bir_pkg::NMI_RST;
        end else begin
            nmi_reg <= i_io_chk;
        end
    end

    // In legacy mode, enabled steering to an illegal number is dropped and flagged
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            err_reg <= bir_pkg::ERR_RST;
        end else begin
            err_reg <= err_next;
        end
    end

    assign o_irq              = irq_reg;
    assign o_nmi              = nmi_reg;
    assign o_routed_irq_input = routed_reg;
    assign o_steer_err        = err_reg;

    // Checks on the delivered requests
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_legacy_upper_zero: assert property (
        $past(i_mode) == bir_pkg::BIR_MODE_LEGACY |-> o_irq[23:16] == 8'h00)
        else $error("upper requests active in legacy mode");

    a_adv_upper_map: assert property (
        $past(i_mode) == bir_pkg::BIR_MODE_ADVANCED |-> o_irq[23:16] == o_routed_irq_input)
        else $error("advanced request does not follow routed input");

    // Each $past(i_rstn) check skips the edge right after reset, where outputs still hold zero
    a_cascade_only: assert property (
        $past(i_rstn) |-> o_irq[2] == $past(i_cascade_irq))
        else $error("request 2 not the cascade alone");

    a_fixed_lines: assert property (
        $past(i_rstn) |-> o_irq[0] == $past(i_timer_irq) && o_irq[1] == $past(i_kbd_irq)
        && o_irq[8] == $past(i_rtc_irq) && o_irq[13] == $past(i_fpu_irq))
        else $error("fixed legacy request mismatch");

    a_nmi_check: assert property (
        $rose(i_io_chk) |=> o_nmi ##1 (o_nmi == $past(i_io_chk)))
        else $error("channel check did not reach nmi");

    a_com_default: assert property (
        i_com_irq && !bir_pkg::bir_steerable(i_com_sel) |=> o_irq[4])
        else $error("serial port not on default request");

    a_lpt_moved: assert property (
        i_lpt_irq && bir_pkg::bir_steerable(i_lpt_sel) |=> o_irq[$past(i_lpt_sel)])
        else $error("parallel port not on chosen request");

    a_steer_first: assert property (
        i_mode == bir_pkg::BIR_MODE_LEGACY && i_steer_en[0] && rt.routed_irq_input[0]
        && bir_pkg::bir_steerable(i_steer_sel[3:0]) |=> o_irq[$past(i_steer_sel[3:0])])
        else $error("steered routed input not delivered");

    a_steer_flag: assert property (
        i_mode == bir_pkg::BIR_MODE_LEGACY && i_steer_en[0]
        && !bir_pkg::bir_steerable(i_steer_sel[3:0]) |=> o_steer_err)
        else $error("illegal steering not flagged");

    a_conn3_wiring: assert property (
        $past(i_rstn) |-> o_routed_irq_input[0] == !$past(i_conn3_int_n[3])
        && o_routed_irq_input[2] == !$past(i_conn3_int_n[0]))
        else $error("connector 3 wiring mismatch");

    a_shared_sixth: assert property (
        $past(i_rstn) |-> o_routed_irq_input[5]
        == ($past(!i_conn1_int_n[0]) || $past(!i_conn2_int_n[1])))
        else $error("sixth routed input not wired-OR");

    a_conn1_eighth: assert property (
        $past(i_rstn) |-> o_routed_irq_input[7]
        == ($past(!i_conn1_int_n[2]) || $past(!i_conn2_int_n[3])))
        else $error("eighth routed input wiring mismatch");

    a_1394_second: assert property (
        !i_ieee1394_inta_n |=> o_routed_irq_input[1])
        else $error("1394 interrupt missing on second input");

    c_adv_mode: cover property (
        i_mode == bir_pkg::BIR_MODE_ADVANCED ##1 o_irq[23]);
    c_two_share: cover property (
        i_mode == bir_pkg::BIR_MODE_LEGACY && i_steer_en[0] && i_steer_en[2]
        && i_steer_sel[3:0] == i_steer_sel[11:8]
        && rt.routed_irq_input[0] && rt.routed_irq_input[2]);
    c_lpt_move: cover property (
        i_lpt_irq && i_lpt_sel == 4'h5);
    c_nmi: cover property (
        o_nmi);

endmodule

// File: tb/bir_src_model.sv
`timescale 1ns/10ps
// PCI interrupt sources: onboard 1394 and three add-in cards
module bir_src_model (
    input  wire logic        i_mclk,
    input  wire logic        i_slow,
    input  wire logic [12:0] i_req,
    output logic             o_ieee1394_inta_n,
    output logic [3:0]       o_conn1_int_n,
    output logic [3:0]       o_conn2_int_n,
    output logic [3:0]       o_conn3_int_n
);
    logic [12:0] lag_reg;

    // Slow mode: every line, 1394 included, follows the request one cycle late
    always_ff @(posedge i_mclk) begin
        lag_reg <= i_req;
    end

    // Req bit 0 is 1394, then INTA..INTD of each card; single-use cards raise INTA
    // Lines are pulled up, so a released line reads high, never the last value
    assign {o_conn3_int_n, o_conn2_int_n, o_conn1_int_n, o_ieee1394_inta_n} =
        ~(i_slow ? lag_reg : i_req);
endmodule

// File: tb/bir_board_irq_routing_bench.sv
`timescale 1ns/10ps
module bir_board_irq_routing_bench;
    logic               i_mclk = 1'b0;
    logic               i_rstn = 1'b0;
    bir_pkg::bir_mode_e i_mode = bir_pkg::BIR_MODE_ADVANCED;
    logic [7:0]         i_steer_en = 8'h00;
    logic [31:0]        i_steer_sel = 32'h00000000;
    logic [10:0]        fix = 11'h000;
    logic [3:0]         i_com_sel = 4'h4;
    logic [3:0]         i_lpt_sel = 4'h7;
    logic               i_io_chk = 1'b0;
    logic               slow = 1'b0;
    logic [12:0]        req = 13'h0000;
    logic               n1394;
    logic [3:0]         c1_n, c2_n, c3_n;
    logic [23:0]        o_irq;
    logic               o_nmi;
    logic [7:0]         o_routed_irq_input;
    logic               o_steer_err;
    int                 error_cnt = 0;
    int                 total_checks = 0;
    // Routed input hit by each source, and request of each fixed source
    int                 rmap[13] = '{1, 5, 6, 7, 4, 6, 5, 4, 7, 2, 3, 1, 0};
    int                 fmap[11] = '{0, 1, 2, 6, 8, 13, 12, 14, 15, 4, 7};

    always #4 i_mclk = ~i_mclk;

    bir_src_model bir_src_model_i (.i_mclk(i_mclk), .i_slow(slow), .i_req(req),
        .o_ieee1394_inta_n(n1394), .o_conn1_int_n(c1_n), .o_conn2_int_n(c2_n),
        .o_conn3_int_n(c3_n));

    bir_board_irq_routing bir_board_irq_routing_i (.i_mclk(i_mclk), .i_rstn(i_rstn),
        .i_mode(i_mode), .i_ieee1394_inta_n(n1394), .i_conn1_int_n(c1_n),
        .i_conn2_int_n(c2_n), .i_conn3_int_n(c3_n), .i_steer_en(i_steer_en),
        .i_steer_sel(i_steer_sel), .i_timer_irq(fix[0]), .i_kbd_irq(fix[1]),
        .i_cascade_irq(fix[2]), .i_floppy_irq(fix[3]), .i_rtc_irq(fix[4]),
        .i_fpu_irq(fix[5]), .i_mouse_irq(fix[6]), .i_ata_pri_irq(fix[7]),
        .i_ata_sec_irq(fix[8]), .i_com_irq(fix[9]), .i_com_sel(i_com_sel),
        .i_lpt_irq(fix[10]), .i_lpt_sel(i_lpt_sel), .i_io_chk(i_io_chk),
        .o_irq(o_irq), .o_nmi(o_nmi), .o_routed_irq_input(o_routed_irq_input),
        .o_steer_err(o_steer_err));

    // Step just past an edge so drives and samples never race the clock
    task automatic tick(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Each PCI line alone lands on one routed input and on 16+k
    task automatic t_route_map();
        i_mode = bir_pkg::BIR_MODE_ADVANCED;
        for (int s = 0; s < 13; s++) begin
            req = 13'h0001 << s;
            tick(1);
            check(o_routed_irq_input, 32'h1 << rmap[s], "routed line");
            check(o_irq, 32'h10000 << rmap[s], "advanced request");
        end
        req = 13'h0000;
        tick(1);
        check(o_irq, 32'h0, "all released");
    endtask

    // 1394 and card 3 INTC share input 2 until both release; slow sources
    task automatic t_share();
        slow = 1'b1;
        req = 13'h0801;
        tick(2);
        check(o_routed_irq_input, 32'h02, "shared set");
        req = 13'h0800;
        tick(2);
        check(o_routed_irq_input, 32'h02, "one still low");
        req = 13'h0000;
        tick(2);
        check(o_routed_irq_input, 32'h00, "shared released");
        slow = 1'b0;
    endtask

    // Sweep every select for input 1 in legacy mode
    task automatic t_steer();
        i_mode = bir_pkg::BIR_MODE_LEGACY;
        i_steer_en = 8'h01;
        req = 13'h1000;
        for (int v = 0; v < 16; v++) begin
            i_steer_sel = 32'(v);
            tick(1);
            if (bir_pkg::STEER_MASK[v]) begin
                check(o_irq, 32'h1 << v, "legal steer");
            end else begin
                check(o_irq, 32'h0, "illegal steer dropped");
            end
            check(o_steer_err, !bir_pkg::STEER_MASK[v], "steer flag");
        end
        // Inputs 1 and 3 share request 9
        i_steer_en = 8'h05;
        i_steer_sel = 32'h00000909;
        req = 13'h1200;
        tick(1);
        check(o_irq, 32'h200, "two on one");
        req = 13'h0200;
        tick(1);
        check(o_irq, 32'h200, "one left");
        req = 13'h0000;
        i_steer_en = 8'h00;
    endtask

    // Fixed sources, movable serial and parallel ports, channel check
    task automatic t_fixed();
        i_mode = bir_pkg::BIR_MODE_LEGACY;
        for (int f = 0; f < 11; f++) begin
            fix = 11'h001 << f;
            tick(1);
            check(o_irq, 32'h1 << fmap[f], "fixed source");
        end
        fix = 11'h600;
        i_com_sel = 4'h3;
        i_lpt_sel = 4'h5;
        tick(1);
        check(o_irq, 32'h28, "ports moved");
        i_com_sel = 4'h2;
        i_lpt_sel = 4'hd;
        tick(1);
        check(o_irq, 32'h90, "illegal falls back");
        fix = 11'h000;
        i_io_chk = 1'b1;
        tick(1);
        check({o_nmi, o_irq}, 32'h1000000, "channel check");
        i_io_chk = 1'b0;
        tick(1);
        check(o_nmi, 32'h0, "check released");
    endtask

    // Advanced mode ignores steering; reset in mid-run clears at once
    task automatic t_adv_reset();
        i_mode = bir_pkg::BIR_MODE_ADVANCED;
        i_steer_en = 8'hff;
        i_steer_sel = 32'h99999999;
        req = 13'h1000;
        fix = 11'h001;
        tick(1);
        check(o_irq, 32'h10001, "advanced no steer");
        i_rstn = 1'b0;
        #2;
        check({o_routed_irq_input, o_irq}, 32'h0, "reset clears lines");
        check({o_nmi, o_steer_err}, 32'h0, "reset clears flags");
        tick(2);
        i_rstn = 1'b1;
        tick(1);
        check(o_irq, 32'h10001, "after reset");
        req = 13'h0000;
        fix = 11'h000;
        i_steer_en = 8'h00;
    endtask

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Watchdog well beyond the 64 or so cycles the tests need
    initial begin
        #40000;
        error_cnt++;
        end_sim();
    end

    initial begin
        tick(5);
        check({o_routed_irq_input, o_irq}, 32'h0, "lines held in reset");
        check({o_nmi, o_steer_err}, 32'h0, "flags held in reset");
        i_rstn = 1'b1;
        tick(2);
        t_route_map();
        t_share();
        t_steer();
        t_fixed();
        t_adv_reset();
        end_sim();
    end
endmodule
